// File: sync_sram_input_control.sv
// Input capture and write control of a pipelined synchronous burst SRAM.
// Assumes all pins except the asynchronous i_sys_rst are synchronous to i_core_clk; one clock, no register map.
`timescale 1ns/1ns
module sync_sram_input_control #(
    parameter int ADDR_W = sram_ctl_pkg::ADDR_W,
    parameter int LANES = sram_ctl_pkg::LANES,
    parameter int LANE_W = sram_ctl_pkg::LANE_W
)
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_clock_qualifier_n,
    input wire logic i_chip_sel1_n,
    input wire logic i_chip_sel2,
    input wire logic i_chip_sel3_n,
    input wire logic i_write_enable_n,
    input wire logic i_advance_or_load,
    input wire logic [ADDR_W-3:0] i_addr_high,
    input wire logic i_low_address_bit_one,
    input wire logic i_low_address_bit_zero,
    input wire logic [LANES-1:0] i_byte_lane_write_select_n,
    input wire logic [LANES*LANE_W-1:0] i_data,
    input wire logic [LANES-1:0] i_parity_io_lanes,
    output logic o_selected,
    output logic o_write_start,
    output logic o_read_start,
    output logic [ADDR_W-1:0] o_access_addr,
    output logic [LANES-1:0] o_lane_write_en,
    output logic [LANES*LANE_W-1:0] o_write_data,
    output logic [LANES-1:0] o_write_parity
);
    // =====================================================================
    // Qualified edge and decode
    // =====================================================================
    logic edge_ok;
    logic sel_now;
    logic is_write;
    logic do_load;
    logic do_advance;
    logic [ADDR_W-1:0] pin_addr;
    logic [ADDR_W-1:0] burst_addr;
    logic selected_reg;
    logic burst_write;
    sram_ctl_pkg::op_kind_t op_reg;
    sram_ctl_pkg::op_kind_t op_next;
    logic [LANES-1:0] lane_en_reg;

    assign edge_ok = !i_clock_qualifier_n;
    assign sel_now = !i_chip_sel1_n && i_chip_sel2 && !i_chip_sel3_n;
    assign pin_addr = {i_addr_high, i_low_address_bit_one,
                       i_low_address_bit_zero};
    assign do_load = edge_ok && !i_advance_or_load && sel_now;
    // A burst continues only while a prior access left the part selected.
    assign do_advance = edge_ok && i_advance_or_load && selected_reg;
    // The write enable has no effect on a masked edge.
    assign is_write = !i_write_enable_n;

    // =====================================================================
    // Access kind
    // =====================================================================
    // The kind changes only on a qualified load edge. Advance edges keep
    // it, which is how a burst inherits the direction of its first access
    // without the controller repeating the write enable.
    always_comb
    begin
        op_next = op_reg;
        case (op_reg)
            sram_ctl_pkg::OP_IDLE:
            begin
                if (do_load)
                begin
                    op_next = is_write ? sram_ctl_pkg::OP_WRITE
                                       : sram_ctl_pkg::OP_READ;
                end
            end
            sram_ctl_pkg::OP_READ,
            sram_ctl_pkg::OP_WRITE:
            begin
                if (do_load)
                begin
                    op_next = is_write ? sram_ctl_pkg::OP_WRITE
                                       : sram_ctl_pkg::OP_READ;
                end
                else if (edge_ok && !i_advance_or_load)
                begin
                    // A load with the selects released ends the burst.
                    op_next = sram_ctl_pkg::OP_IDLE;
                end
            end
            default:
            begin
                op_next = sram_ctl_pkg::OP_IDLE;
            end
        endcase
    end

    // Advance cycles keep the direction of the access they continue.
    assign burst_write = (op_reg == sram_ctl_pkg::OP_WRITE);

    // =====================================================================
    // Burst counter
    // =====================================================================
    // The counter sees only qualified load and advance strobes, so a
    // masked edge can never move the access address.
    burst_addr_counter #(
        .ADDR_W(ADDR_W),
        .BURST_W(sram_ctl_pkg::BURST_W)
    ) u_burst
    (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_load(do_load),
        .i_advance(do_advance),
        .i_addr(pin_addr),
        .o_addr(burst_addr)
    );

    // =====================================================================
    // Cycle state
    // =====================================================================
    // A masked edge holds op_reg and selected_reg, so the previous cycle is
    // extended and the part is not deselected.
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            op_reg <= sram_ctl_pkg::OP_IDLE;
            selected_reg <= 1'b0;
        end
        else if (edge_ok)
        begin
            op_reg <= op_next;
            if (!i_advance_or_load)
            begin
                selected_reg <= sel_now;
            end
        end
    end

    // The start pulses last one cycle. A masked edge clears them, so a
    // stalled access is never reported to the array twice.
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_write_start <= 1'b0;
            o_read_start <= 1'b0;
        end
        else
        begin
            o_write_start <= do_load && is_write;
            o_read_start <= do_load && !is_write;
        end
    end

    // =====================================================================
    // Byte-lane write enables
    // =====================================================================
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1)
        begin : g_lane
            always_ff @(posedge i_core_clk or posedge i_sys_rst)
            begin
                if (i_sys_rst)
                begin
                    lane_en_reg[g] <= 1'b0;
                end
                else if (edge_ok)
                begin
                    lane_en_reg[g] <= !i_byte_lane_write_select_n[g] &&
                        ((do_load && is_write) ||
                         (do_advance && burst_write));
                end
                else
                begin
                    lane_en_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Data and parity are captured as whole words, without their lane selects.
    // They are taken on every qualified edge, not only on writes: the
    // array only looks at them under a lane enable, and skipping the
    // decode here keeps the data path one register deep.
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_write_data <= '0;
            o_write_parity <= '0;
        end
        else if (edge_ok)
        begin
            o_write_data <= i_data;
            o_write_parity <= i_parity_io_lanes;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    // Every output is a register, so the array sees no decode glitches.
    assign o_lane_write_en = lane_en_reg;
    assign o_access_addr = burst_addr;
    assign o_selected = selected_reg;
endmodule

// File: sram_ctl_pkg.sv
// Package for the synchronous burst SRAM input control block.
// Assumes one core clock; no register map, all control is via pins.
package sram_ctl_pkg;
    // =====================================================================
    // Geometry
    // =====================================================================
    localparam int ADDR_W = 20;
    localparam int LANES = 8;
    localparam int LANE_W = 8;
    localparam int BURST_W = 2;
    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
    // =====================================================================
    // Cycle kinds
    // =====================================================================
    typedef enum logic [1:0]
    {
        OP_IDLE = 2'h0,
        OP_READ = 2'h1,
        OP_WRITE = 2'h3
    } op_kind_t;
endpackage

// File: burst_addr_counter.sv
// Burst address counter for the SRAM input control block.
// Assumes load and advance are already qualified by the clock qualifier.
`timescale 1ns/1ns
module burst_addr_counter #(
    parameter int ADDR_W = sram_ctl_pkg::ADDR_W,
    parameter int BURST_W = sram_ctl_pkg::BURST_W
)
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_load,
    input wire logic i_advance,
    input wire logic [ADDR_W-1:0] i_addr,
    output logic [ADDR_W-1:0] o_addr
);
    logic [ADDR_W-BURST_W-1:0] base_reg;
    logic [BURST_W-1:0] count_reg;

    // =====================================================================
    // Counter
    // =====================================================================
    // Only the low bits wrap so a burst stays inside its aligned group.
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            base_reg <= '0;
            count_reg <= sram_ctl_pkg::BURST_ZERO;
        end
        else if (i_load)
        begin
            base_reg <= i_addr[ADDR_W-1:BURST_W];
            count_reg <= i_addr[BURST_W-1:0];
        end
        else if (i_advance)
        begin
            count_reg <= count_reg + sram_ctl_pkg::BURST_STEP;
        end
    end

    assign o_addr = {base_reg, count_reg};
endmodule

// File: sync_sram_input_control_asserts.sv
// Port checker for the SRAM input control block.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module sync_sram_input_control_asserts #(
    parameter int ADDR_W = sram_ctl_pkg::ADDR_W,
    parameter int LANES = sram_ctl_pkg::LANES
)
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_clock_qualifier_n,
    input wire logic i_chip_sel1_n,
    input wire logic i_chip_sel2,
    input wire logic i_chip_sel3_n,
    input wire logic i_write_enable_n,
    input wire logic i_advance_or_load,
    input wire logic [ADDR_W-3:0] i_addr_high,
    input wire logic i_low_address_bit_one,
    input wire logic i_low_address_bit_zero,
    input wire logic [LANES-1:0] i_byte_lane_write_select_n,
    input wire logic o_selected,
    input wire logic o_write_start,
    input wire logic [ADDR_W-1:0] o_access_addr,
    input wire logic [LANES-1:0] o_lane_write_en
);
    // ========================================
    // Properties
    // ========================================
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    wire logic q = !i_clock_qualifier_n;
    wire logic sel = !i_chip_sel1_n && i_chip_sel2 && !i_chip_sel3_n;
    wire logic ld = q && !i_advance_or_load;
    wire logic wld = ld && sel && !i_write_enable_n;
    wire logic [ADDR_W-1:0] a = {i_addr_high, i_low_address_bit_one,
        i_low_address_bit_zero};
    // The burst count wraps inside the low two bits only.
    wire logic [ADDR_W-1:0] nxt = {o_access_addr[ADDR_W-1:2],
        o_access_addr[1:0] + 2'h1};
    property p_mask; !q |=> $stable(o_access_addr) && $stable(o_selected);
    endproperty
    a_mask: assert property (p_mask) else $error("masked edge moved");
    property p_weq; !q |=> !o_write_start && o_lane_write_en == '0; endproperty
    a_weq: assert property (p_weq) else $error("masked write");
    property p_wst; wld |=> o_write_start; endproperty
    a_wst: assert property (p_wst) else $error("write did not start");
    property p_nowe;
        ld && i_write_enable_n |=> o_lane_write_en == '0 && !o_write_start;
    endproperty
    a_nowe: assert property (p_nowe) else $error("lanes no enable");
    property p_lane;
        wld |=> o_lane_write_en == ~$past(i_byte_lane_write_select_n);
    endproperty
    a_lane: assert property (p_lane) else $error("wrong lanes");
    property p_load; ld && sel |=> o_access_addr == $past(a); endproperty
    a_load: assert property (p_load) else $error("bad load");
    property p_adv;
        q && i_advance_or_load && o_selected |=> o_access_addr == $past(nxt);
    endproperty
    a_adv: assert property (p_adv) else $error("bad advance");
    property p_sel; ld |=> o_selected == $past(sel); endproperty
    a_sel: assert property (p_sel) else $error("bad select");
    c_write: cover property (wld);
    c_burst: cover property (q && i_advance_or_load && o_selected ##1 q);
    c_stall: cover property (!q ##1 !q);
endmodule
bind sync_sram_input_control sync_sram_input_control_asserts #(
    .ADDR_W(ADDR_W), .LANES(LANES)) i_sync_sram_input_control_asserts (.*);

// File: sram_ctrl_model.sv
// Memory controller model that drives the SRAM control pins.
// Assumes one clock; it changes its pins at the falling edge.
`timescale 1ns/1ns
module sram_ctrl_model #(
    parameter logic [31:0] SEED = 32'h00000001
)
(
    input wire logic i_core_clk,
    output logic o_qual_n,
    output logic [2:0] o_sels,
    output logic o_write_n,
    output logic o_advance,
    output logic [19:0] o_addr,
    output logic [7:0] o_lane_sel_n,
    output logic [63:0] o_data,
    output logic [7:0] o_par
);
    bit desel = 1'b1;
    initial
    begin
        void'($urandom(SEED));
        forever
        begin
            if (o_qual_n === 1'b0 && o_advance === 1'b0)
                desel = o_sels != 3'h2;
            o_qual_n = ($urandom % 4) == 0;
            o_sels = ($urandom % 6) == 0 ? 3'($urandom) : 3'h2;
            o_write_n = 1'($urandom);
            o_advance = 1'($urandom) && !desel;
            o_addr = 20'($urandom);
            o_lane_sel_n = 8'($urandom);
            o_data = {$urandom, $urandom};
            o_par = 8'($urandom);
            @(negedge i_core_clk);
        end
    end
endmodule

// File: sync_sram_input_control_tb.sv
// Self-checking bench for the SRAM input control block.
// Assumes the controller model supplies every input except the clock and i_sys_rst.
`timescale 1ns/1ns
module sync_sram_input_control_tb;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_clock_qualifier_n, i_chip_sel1_n, i_chip_sel2, i_chip_sel3_n;
    logic i_write_enable_n, i_advance_or_load;
    logic [19:0] addr, o_access_addr, e_addr;
    logic [7:0] i_byte_lane_write_select_n, i_parity_io_lanes;
    logic [7:0] o_lane_write_en, o_write_parity, e_lane, e_par;
    logic [63:0] i_data, o_write_data, e_data;
    logic o_selected, o_write_start, o_read_start;
    logic e_sel, e_ws, e_rs, wr, s;
    int n_fail = 0;
    int checked = 0;
    always #2 i_core_clk = ~i_core_clk;
    sram_ctrl_model #(.SEED(32'h4AC03032)) i_sram_ctrl_model (
        .i_core_clk(i_core_clk), .o_qual_n(i_clock_qualifier_n),
        .o_sels({i_chip_sel1_n, i_chip_sel2, i_chip_sel3_n}),
        .o_write_n(i_write_enable_n), .o_advance(i_advance_or_load),
        .o_addr(addr), .o_lane_sel_n(i_byte_lane_write_select_n),
        .o_data(i_data), .o_par(i_parity_io_lanes));
    sync_sram_input_control i_sync_sram_input_control (.*,
        .i_addr_high(addr[19:2]), .i_low_address_bit_one(addr[1]),
        .i_low_address_bit_zero(addr[0]));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ========================================
    // Reference model
    // ========================================
    always @(posedge i_core_clk)
    begin
        s = !i_chip_sel1_n && i_chip_sel2 && !i_chip_sel3_n;
        {e_ws, e_rs, e_lane} = '0;
        if (i_sys_rst)
            {e_sel, wr, e_addr, e_data, e_par} = '0;
        else if (!i_clock_qualifier_n)
        begin
            {e_data, e_par} = {i_data, i_parity_io_lanes};
            if (!i_advance_or_load)
            begin
                e_sel = s;
                wr = s && !i_write_enable_n;
                e_ws = wr;
                e_rs = s && i_write_enable_n;
                if (s)
                    e_addr = addr;
            end
            else if (e_sel)
                e_addr[1:0] = e_addr[1:0] + 2'h1;
            if (e_sel && wr)
                e_lane = ~i_byte_lane_write_select_n;
        end
        #1;
        chk(o_selected, e_sel);
        chk(o_write_start, e_ws);
        chk(o_read_start, e_rs);
        chk(o_lane_write_en, e_lane);
        chk(o_write_data, e_data);
        chk(o_write_parity, e_par);
        if (e_sel)
            chk(o_access_addr, e_addr);
    end
    // A second reset in mid-run shows that no burst survives it.
    initial
    begin
        repeat (8) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        repeat (1000) @(negedge i_core_clk);
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        repeat (1000) @(negedge i_core_clk);
        end_of_test();
    end
    initial
    begin
        #20000;
        n_fail++;
        end_of_test();
    end
endmodule
